/* hdl/sipo_latch_pkg.sv */
/*
  constants for the serial-in parallel-out output expander.
  assumes one core clock (REF_CLK) and a shift clock driven by the host.
*/
// How it works
// - eight shift stages, loaded serially, read parallel
// - eight-bit storage register drives parallel outputs
// - shift and storage use separate clocks
// - shift clock rise takes serial_in, shifts once
// - storage clock rise copies all stages
// - low clear zeroes shift stages at once only
// - last shift stage drives the chain output
// - high output enable floats the parallel outputs
// - output enable never changes stored data
package sipo_latch_pkg;
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int PAR_W = 8;
  localparam int SYNC_LEN = 3;
  localparam logic [PAR_W-1:0] STAGE_CLR = 8'h00;
  localparam logic [PAR_W-1:0] STORE_RST = 8'h00;
  localparam logic [PAR_W-1:0] OE_ALL_OFF = 8'h00;
  localparam logic [PAR_W-1:0] OE_ALL_ON = 8'hFF;
  localparam logic [SYNC_LEN-1:0] SYNC_RST = 3'h0;
  localparam logic [SYNC_LEN-1:0] OE_SYNC_RST = 3'h7;
endpackage

/* hdl/sipo_latch.sv */
/*
  serial-in parallel-out shift stages feeding a storage register.
  the shift stages run on SHIFT_CLOCK; storage, output enable and the
  storage clock pin are handled on REF_CLK. the host is expected to
  leave the shift stages still while it pulses the storage clock.
*/
module sipo_latch
  import sipo_latch_pkg::*;
(
  // core clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // serial link from the host
  input wire logic SHIFT_CLOCK,
  input wire logic SHIFT_CLEAR_N,
  input wire logic SERIAL_IN,
  input wire logic STORE_CLOCK,
  input wire logic OUT_ENABLE_N,
  // chaining output
  output logic CHAIN_OUT,
  // parallel outputs, three-state
  output logic [sipo_latch_pkg::PAR_W-1:0] PAR_OUT,
  output logic [sipo_latch_pkg::PAR_W-1:0] PAR_OUT_OE
);
  import sipo_latch_pkg::*;

  // ****************************************
  // shift domain
  // ****************************************
  typedef struct packed {
    logic [PAR_W-1:0] stages;
  } shift_t;

  shift_t sh_r;
  shift_t sh_nxt;

  // shift toward output 7, new bit lands in stage 0
  always_comb
  begin
    sh_nxt = sh_r;
    sh_nxt.stages = {sh_r.stages[PAR_W-2:0], SERIAL_IN};
  end

  // clear is asynchronous and overrides the shift clock
  always_ff @(posedge SHIFT_CLOCK or negedge SHIFT_CLEAR_N)
  begin
    if (!SHIFT_CLEAR_N)
    begin
      sh_r.stages <= STAGE_CLR;
    end
    else
    begin
      sh_r <= sh_nxt;
    end
  end

  // chain output is the last stage flop itself, no enable
  assign CHAIN_OUT = sh_r.stages[PAR_W-1];

  // ****************************************
  // core domain
  // ****************************************
  typedef struct packed {
    logic [SYNC_LEN-1:0] clk_s;
    logic [SYNC_LEN-1:0] oe_s;
    logic [PAR_W-1:0] stg_s1;
    logic [PAR_W-1:0] stg_s2;
    logic [PAR_W-1:0] stg_s3;
    logic clk_lvl;
    logic pend;
    logic [PAR_W-1:0] storage;
    logic [PAR_W-1:0] oe;
  } core_t;

  core_t co_r;
  core_t co_nxt;
  logic store_rise;
  logic stg_agree;

  // edge of the agreed storage clock level, and stable stage word
  assign store_rise = co_r.clk_s[1] && co_r.clk_s[2] && !co_r.clk_lvl;
  assign stg_agree = (co_r.stg_s2 == co_r.stg_s3);

  // synchronisers, storage transfer and enable tracking
  always_comb
  begin
    co_nxt = co_r;
    co_nxt.clk_s = {co_r.clk_s[1:0], STORE_CLOCK};
    co_nxt.oe_s = {co_r.oe_s[1:0], OUT_ENABLE_N};
    co_nxt.stg_s1 = sh_r.stages;
    co_nxt.stg_s2 = co_r.stg_s1;
    co_nxt.stg_s3 = co_r.stg_s2;
    if (co_r.clk_s[1] == co_r.clk_s[2])
    begin
      co_nxt.clk_lvl = co_r.clk_s[2];
    end
    // copy once the stage word is settled, else hold the request
    if (store_rise || co_r.pend)
    begin
      if (stg_agree)
      begin
        co_nxt.storage = co_r.stg_s3;
        co_nxt.pend = 1'b0;
      end
      else
      begin
        co_nxt.pend = 1'b1;
      end
    end
    // enable touches only the drivers, never the data
    if (co_r.oe_s[1] == co_r.oe_s[2])
    begin
      co_nxt.oe = co_r.oe_s[2] ? OE_ALL_OFF : OE_ALL_ON;
    end
  end

  // register core state
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      co_r.clk_s <= SYNC_RST;
      co_r.oe_s <= OE_SYNC_RST;
      co_r.stg_s1 <= STAGE_CLR;
      co_r.stg_s2 <= STAGE_CLR;
      co_r.stg_s3 <= STAGE_CLR;
      co_r.clk_lvl <= 1'b0;
      co_r.pend <= 1'b0;
      co_r.storage <= STORE_RST;
      co_r.oe <= OE_ALL_OFF;
    end
    else
    begin
      co_r <= co_nxt;
    end
  end

  assign PAR_OUT = co_r.storage;
  assign PAR_OUT_OE = co_r.oe;

  // ****************************************
  // checks
  // ****************************************
  AST_SHIFT_IN: assert property (@(posedge SHIFT_CLOCK) disable iff (!SHIFT_CLEAR_N)
    ##1 sh_r.stages[0] == $past(SERIAL_IN))
    else $error("stage 0 did not take serial input");

  AST_SHIFT_MOVE: assert property (@(posedge SHIFT_CLOCK) disable iff (!SHIFT_CLEAR_N)
    ##1 sh_r.stages[PAR_W-1:1] == $past(sh_r.stages[PAR_W-2:0]))
    else $error("stages did not move toward output 7");

  AST_CHAIN: assert property (@(posedge SHIFT_CLOCK) disable iff (!SHIFT_CLEAR_N)
    ##1 CHAIN_OUT == $past(sh_r.stages[PAR_W-2]))
    else $error("chain output does not follow last stage");

  AST_CLEAR: assert property (@(posedge REF_CLK) disable iff (RST)
    !SHIFT_CLEAR_N |-> sh_r.stages == STAGE_CLR && CHAIN_OUT == 1'b0)
    else $error("shift stages not cleared");

  AST_CLEAR_KEEPS: assert property (@(posedge REF_CLK) disable iff (RST)
    !SHIFT_CLEAR_N && !store_rise && !co_r.pend |=> $stable(PAR_OUT))
    else $error("clear disturbed storage");

  AST_STORE: assert property (@(posedge REF_CLK) disable iff (RST)
    store_rise && stg_agree |=> PAR_OUT == $past(co_r.stg_s3))
    else $error("storage did not copy stages");

  AST_STORE_ONLY: assert property (@(posedge REF_CLK) disable iff (RST)
    !store_rise && !co_r.pend |=> $stable(PAR_OUT))
    else $error("storage changed without storage clock");

  AST_OE_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
    co_r.oe_s[1] && co_r.oe_s[2] |=> PAR_OUT_OE == OE_ALL_OFF)
    else $error("outputs still driven with enable high");

  AST_OE_ON: assert property (@(posedge REF_CLK) disable iff (RST)
    !co_r.oe_s[1] && !co_r.oe_s[2] |=> PAR_OUT_OE == OE_ALL_ON)
    else $error("outputs not driven with enable low");

  AST_OE_KEEPS: assert property (@(posedge REF_CLK) disable iff (RST)
    $changed(co_r.oe) && !$past(store_rise) && !$past(co_r.pend) |-> $stable(PAR_OUT))
    else $error("enable change altered storage");

  // ****************************************
  // storage handshake, driver, reset and clear checks
  // ****************************************

  // a rise seen while the word moves must leave a request behind
  AST_PEND_SET: assert property (@(posedge REF_CLK) disable iff (RST)
    store_rise && !stg_agree |=> co_r.pend)
    else $error("unsettled store request was lost");

  // a held request completes as soon as the word settles
  AST_PEND_DONE: assert property (@(posedge REF_CLK) disable iff (RST)
    co_r.pend && stg_agree |=> !co_r.pend && PAR_OUT == $past(co_r.stg_s3))
    else $error("held store request not completed");

  // one storage clock rise gives exactly one transfer strobe
  AST_ONE_RISE: assert property (@(posedge REF_CLK) disable iff (RST)
    store_rise |=> !store_rise)
    else $error("storage clock rise seen twice");

  // agreed level follows the synchronised pin
  AST_LEVEL_TRACK: assert property (@(posedge REF_CLK) disable iff (RST)
    co_r.clk_s[1] == co_r.clk_s[2] |=> co_r.clk_lvl == $past(co_r.clk_s[2]))
    else $error("storage clock level not tracked");

  // all eight drivers switch together, never a mix
  AST_OE_WHOLE: assert property (@(posedge REF_CLK) disable iff (RST)
    PAR_OUT_OE == OE_ALL_ON || PAR_OUT_OE == OE_ALL_OFF)
    else $error("output drivers split");

  // outputs start from the reset word with drivers off
  AST_RESET_OUT: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(RST) |-> PAR_OUT == STORE_RST && PAR_OUT_OE == OE_ALL_OFF)
    else $error("outputs not at reset values");

  // clear leaves the chain output low on every core edge
  AST_CHAIN_CLEAR: assert property (@(posedge REF_CLK) disable iff (RST)
    !SHIFT_CLEAR_N |-> !CHAIN_OUT)
    else $error("chain output not low during clear");
endmodule

/* test/host_model.sv */
/*
  host model: shifts one byte out, far bit first.
  assumes the block samples data on shift clock rise.
*/
module host_model (
  // frame request
  input wire logic [7:0] byte_in,
  input wire logic go,
  // serial link
  output logic SHIFT_CLOCK,
  output logic SERIAL_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  // one frame per go rise, 6 ns clock, still outside frames
  initial
  begin
    SHIFT_CLOCK = 1'b0;
    SERIAL_IN = 1'b0;
  end
  always @(posedge go)
  begin
    #1.7;
    for (int i = 7; i >= 0; i--)
    begin
      SERIAL_IN = byte_in[i];
      #3 SHIFT_CLOCK = 1'b1;
      #3 SHIFT_CLOCK = 1'b0;
    end
    SERIAL_IN = ~SERIAL_IN;
  end
endmodule

/* test/test_serial_in_parallel_out_latch.sv */
/*
  bench for sipo_latch, host model on the shift link.
  assumes the design package is compiled first.
*/
module test_serial_in_parallel_out_latch;
  timeunit 1ns;
  timeprecision 1ps;
  import sipo_latch_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clr_n = 1'b1;
  logic store = 1'b0;
  logic oe_n = 1'b0;
  logic go = 1'b0;
  logic [7:0] tx = 8'h00;
  logic sck, sin, chain;
  logic [PAR_W-1:0] pout, poe;
  int bad_count = 0;
  int compares = 0;
  // core clock, 50 MHz
  always #10 ref_clk = ~ref_clk;
  host_model i_host (.byte_in(tx), .go(go), .SHIFT_CLOCK(sck), .SERIAL_IN(sin));
  sipo_latch i_dut (.REF_CLK(ref_clk), .RST(rst), .SHIFT_CLOCK(sck), .SHIFT_CLEAR_N(clr_n),
    .SERIAL_IN(sin), .STORE_CLOCK(store), .OUT_ENABLE_N(oe_n), .CHAIN_OUT(chain),
    .PAR_OUT(pout), .PAR_OUT_OE(poe));
  // shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send(input logic [7:0] b);
    tx <= b;
    go <= 1'b1;
    tick(2);
    go <= 1'b0;
    tick(8);
  endtask
  task automatic pulse();
    store <= 1'b1;
    tick(4);
    store <= 1'b0;
    tick(4);
  endtask
  task automatic clear();
    clr_n <= 1'b0;
    tick(2);
    clr_n <= 1'b1;
    tick(1);
  endtask
  // scenarios
  task automatic t_load();
    clear();
    send(8'hA5);
    chk({7'h00, chain}, 8'h01);
    pulse();
    chk(pout, 8'hA5);
    chk(poe, OE_ALL_ON);
    $display("load test done");
  endtask
  task automatic t_clear();
    send(8'hC3);
    chk(pout, 8'hA5);
    chk({7'h00, chain}, 8'h01);
    clear();
    chk({7'h00, chain}, 8'h00);
    chk(pout, 8'hA5);
    pulse();
    chk(pout, STAGE_CLR);
    $display("clear test done");
  endtask
  task automatic t_oe();
    send(8'h81);
    pulse();
    oe_n <= 1'b1;
    tick(6);
    chk(poe, OE_ALL_OFF);
    chk(pout, 8'h81);
    chk({7'h00, chain}, 8'h01);
    oe_n <= 1'b0;
    tick(6);
    chk(poe, OE_ALL_ON);
    $display("enable test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    tick(16);
    rst <= 1'b0;
    tick(2);
    t_load();
    t_clear();
    t_oe();
    final_report();
  end
  // watchdog, tests need about 1.8 us
  initial
  begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule
